/* File: tb/lsrb_checker.sv */
// Concurrent checks on the pins of the light sensor register bank.
// Assumes a bus bit of 16 clocks, 8 low and 8 high, from the bench host.
`timescale 1ns/1ps
module lsrb_checker (
  input wire logic        SYS_CLK,
  input wire logic        RSTN,
  input wire logic        SCL_IN,
  input wire logic        SDA_IN,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE_N,
  input wire logic        INT_OUT,
  input wire logic        INT_OE_N,
  input wire logic [15:0] SENSOR_COUNT
);
  logic [4:0] scl_high;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // Cycles that SCL has been high
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN || !SCL_IN) scl_high <= 5'h00;
    else if (scl_high != 5'h1F) scl_high <= scl_high + 5'h01;
  end
  sequence s_held_low;
    !SDA_OE_N [*8];
  endsequence
  a_reset_release: assert property (disable iff (1'b0)
    !RSTN |=> SDA_OE_N && INT_OE_N) else $error("pins driven in reset");
  a_int_out_zero: assert property (INT_OUT == 1'b0)
    else $error("interrupt pin driven high");
  a_sda_out_zero: assert property (SDA_OUT == 1'b0)
    else $error("data pin driven high");
  a_sda_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
    else $error("data changed while clock high");
  a_bit_held: assert property ($fell(SDA_OE_N) |-> s_held_low)
    else $error("ack or data bit too short");
  a_idle_release: assert property (scl_high > 5'h14 |-> SDA_OE_N)
    else $error("data held low on idle bus");
  a_start_release: assert property (
    SCL_IN && $fell(SDA_IN) |-> SDA_OE_N)
    else $error("device low at start");
  a_int_settle: assert property (
    $changed(INT_OE_N) |=> $stable(INT_OE_N) [*8])
    else $error("interrupt pin toggles");
endmodule // lsrb_checker

bind lsrb_top lsrb_checker u_checker (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .INT_OUT(INT_OUT), .INT_OE_N(INT_OE_N), .SENSOR_COUNT(SENSOR_COUNT));

/* File: tb/lsrb_host_model.sv */
// Two-wire bus master host model with a 160 ns bus clock.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module lsrb_host_model #(
  parameter int unsigned WAIT_CYC = lsrb_pkg::POWER_ON_WAIT_CYC
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_rel
);
  logic last_ack;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    last_ack = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data moves mid low phase, sampled at the end of the high phase
  task automatic bit_io(input logic o, output logic i);
    tick(4);
    sda_rel = o;
    tick(4);
    scl = 1'b1;
    tick(8);
    i = sda;
    scl = 1'b0;
  endtask
  task automatic start_bit();
    if (scl === 1'b0) begin
      tick(4);
      sda_rel = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(8);
    end
    sda_rel = 1'b0;
    tick(8);
    scl = 1'b0;
  endtask
  task automatic stop_bit();
    tick(4);
    sda_rel = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_rel = 1'b1;
    tick(8);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic i;
    for (int k = 7; k >= 0; k--) bit_io(b[k], i);
    bit_io(1'b1, i);
    ack = ~i;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra,
                    input int n, input logic [15:0] d);
    logic a;
    start_bit();
    send_byte({dev, 1'b0}, last_ack);
    send_byte(ra, a);
    for (int k = 0; k < n; k++) send_byte(d[8*k +: 8], a);
    stop_bit();
    if (ra == 8'h00 && d[7:0] == 8'h08) tick(WAIT_CYC);
  endtask
  task automatic rd(input logic [7:0] ra, input int n,
                    output logic [15:0] v);
    logic a;
    logic i;
    v = 16'h0000;
    start_bit();
    send_byte({lsrb_pkg::DEV_ADDR, 1'b0}, a);
    send_byte(ra, a);
    start_bit();
    send_byte({lsrb_pkg::DEV_ADDR, 1'b1}, a);
    for (int k = 0; k < 8 * n; k++) begin
      bit_io(1'b1, i);
      v[8 * (k / 8) + 7 - k % 8] = i;
      if (k % 8 == 7) bit_io(k == 8 * n - 1, i);
    end
    stop_bit();
  endtask
endmodule // lsrb_host_model

/* File: tb/lsrb_tb_top.sv */
// Self-checking bench of the light sensor register bank.
// Assumes the host model drives the bus and pull-ups end both pins.
`timescale 1ns/1ps
module lsrb_tb_top;
  localparam int unsigned SHORT = 100;
  logic        clk;
  logic        rstn;
  logic        scl;
  logic        sda_rel;
  logic        sda_oe_n;
  logic        sda_out;
  logic        int_oe_n;
  logic        int_out;
  logic [15:0] sensor_count;
  logic [15:0] v;
  int          n_mismatch;
  int          check_count;
  int          cycles;
  wire         sda = sda_rel & (sda_oe_n | sda_out);
  lsrb_top #(.SHORTEST_CYC(SHORT)) dut (.SYS_CLK(clk), .RSTN(rstn),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
    .INT_OUT(int_out), .INT_OE_N(int_oe_n), .SENSOR_COUNT(sensor_count));
  lsrb_host_model #(.WAIT_CYC(300)) host (.clk(clk), .sda(sda),
    .scl(scl), .sda_rel(sda_rel));
  always #5 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [7:0] ra, input int n, input logic [15:0] d);
    host.wr(lsrb_pkg::DEV_ADDR, ra, n, d);
  endtask
  task automatic rd_chk(input logic [7:0] ra, input int n,
                        input logic [15:0] exp);
    host.rd(ra, n, v);
    check(v, exp);
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    wait_cyc(20);
    rstn = 1'b1;
    wait_cyc(3);
  endtask
  task automatic t_defaults();
    logic [15:0] exp [5];
    exp = '{16'h0008, 16'h0302, 16'h0800, 16'h0000, lsrb_pkg::PART_CODE};
    for (int k = 0; k < 5; k++) begin
      rd_chk(8'(2 * k), 2, exp[k]);
    end
    rd_chk(8'h0A, 1, 16'h0000);
  endtask
  task automatic t_illegal();
    put(8'h02, 2, 16'h0105);
    rd_chk(8'h02, 2, 16'h0105);
    put(8'h02, 2, 16'hFFFF);
    rd_chk(8'h02, 2, 16'h0302);
    put(8'h00, 1, 16'h000A);
    put(8'h00, 2, 16'hFFFF);
    rd_chk(8'h00, 2, 16'h0008);
  endtask
  task automatic t_readonly();
    for (int k = 0; k < 2; k++) put(8'(6 + 2 * k), 2, 16'h1234);
    check(16'(host.last_ack), 16'h0001);
    rd_chk(8'h06, 2, 16'h0000);
    rd_chk(8'h08, 2, lsrb_pkg::PART_CODE);
    host.wr(7'h3A, 8'h04, 1, 16'h0055);
    check(16'(host.last_ack), 16'h0000);
    rd_chk(8'h04, 1, 16'h0000);
  endtask
  task automatic t_test_modes();
    logic [15:0] fixed [3];
    fixed = '{16'h0123, 16'h5555, 16'hAAAA};
    sensor_count = 16'h0123;
    wait_cyc(3 * (SHORT << 5));
    rd_chk(8'h06, 2, 16'h0123);
    for (int k = 0; k < 3; k++) begin
      put(8'h00, 1, 16'h0009 + 16'(k));
      rd_chk(8'h06, 2, fixed[k]);
    end
    put(8'h00, 1, 16'h0008);
    rd_chk(8'h06, 2, 16'h0123);
  endtask
  task automatic t_interrupt();
    put(8'h02, 1, 16'h0007);
    put(8'h04, 2, 16'h0100);
    for (int k = 0; k < 4; k++) begin
      sensor_count = k[1] ? 16'h0100 : 16'h0101;
      put(8'h03, 1, k[0] ? 16'h0001 : 16'h0002);
      wait_cyc(3 * SHORT);
      check(16'(int_oe_n), 16'(k[0] ^ k[1]));
    end
    sensor_count = 16'h0101;
    put(8'h03, 1, 16'h0003);
    wait_cyc(3 * SHORT);
    check(16'(int_oe_n), 16'h0001);
    put(8'h03, 1, 16'h0002);
    wait_cyc(3 * SHORT);
    check(16'(int_oe_n), 16'h0000);
    put(8'h00, 1, 16'h0000);
    sensor_count = 16'h0000;
    wait_cyc(3 * SHORT);
    check(16'(int_oe_n), 16'h0001);
    rd_chk(8'h04, 2, 16'h0100);
    rd_chk(8'h06, 2, 16'h0101);
    put(8'h00, 1, 16'h0008);
    wait_cyc(3 * SHORT);
    check(16'(int_oe_n), 16'h0001);
  endtask
  task automatic t_periods();
    int n;
    int lim;
    sensor_count = 16'h0200;
    wait_cyc(3 * SHORT);
    for (int c = 0; c < 8; c++) begin
      put(8'h02, 1, 16'(c));
      put(8'h01, 1, 16'h0010);
      check(16'(int_oe_n), 16'h0001);
      n = 0;
      lim = SHORT << (7 - c);
      while (int_oe_n === 1'b1 && n < (SHORT << 7) + 50) begin
        wait_cyc(1);
        n++;
      end
      check(16'(n + 8 >= lim && n <= lim + 4), 16'h0001);
    end
    rd_chk(8'h01, 1, 16'h0000);
    rd_chk(8'h02, 1, 16'h0007);
  endtask
  initial begin
    clk = 1'b0;
    sensor_count = 16'h0000;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    do_reset();
    t_defaults();
    t_illegal();
    t_readonly();
    t_test_modes();
    t_interrupt();
    t_periods();
    sensor_count = 16'h0000;
    do_reset();
    t_defaults();
    summarize();
  end
endmodule // lsrb_tb_top

/* File: verilog/lsrb_period_timer.sv */
// Exposure period timer: one pulse at the end of each period.
// Assumes code is a legal period code 0 to 7 held in the register bank.
`timescale 1ns/1ps
module lsrb_period_timer #(
  parameter int unsigned SHORTEST_CYC = lsrb_pkg::SHORTEST_PERIOD_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] code,
  output logic            period_end
);

  logic [31:0] count;
  logic [31:0] limit;

  // Code 7 is the shortest period, each lower code doubles it
  assign limit = 32'(SHORTEST_CYC) << (3'h7 - code);

  always_ff @(posedge clk) begin
    if (!rstn || restart || !run) begin
      count      <= 32'h0000_0000;
      period_end <= 1'b0;
    end else if (count >= limit - 32'h0000_0001) begin
      count      <= 32'h0000_0000;
      period_end <= 1'b1;
    end else begin
      count      <= count + 32'h0000_0001;
      period_end <= 1'b0;
    end
  end

endmodule // lsrb_period_timer

/* File: verilog/lsrb_pkg.sv */
// Constants, codes and carrier types of the light sensor register bank.
// Assumes a 100 MHz system clock; used by scope by every design file except lsrb_sync.
package lsrb_pkg;

  // Bus address of the sensor and the register map
  localparam logic [6:0] DEV_ADDR    = 7'h39;
  localparam logic [7:0] REG_POWER   = 8'h00;
  localparam logic [7:0] REG_RESET   = 8'h01;
  localparam logic [7:0] REG_PERIOD  = 8'h02;
  localparam logic [7:0] REG_IRQ_SEL = 8'h03;
  localparam logic [7:0] REG_THR_LO  = 8'h04;
  localparam logic [7:0] REG_THR_HI  = 8'h05;
  localparam logic [7:0] REG_CNT_LO  = 8'h06;
  localparam logic [7:0] REG_CNT_HI  = 8'h07;
  localparam logic [7:0] REG_PART_LO = 8'h08;
  localparam logic [7:0] REG_PART_HI = 8'h09;

  // Power state codes
  localparam logic [7:0] PWR_OFF   = 8'h00;
  localparam logic [7:0] PWR_ON    = 8'h08;
  localparam logic [7:0] PWR_TEST1 = 8'h09;
  localparam logic [7:0] PWR_TEST2 = 8'h0A;
  localparam logic [7:0] PWR_TEST3 = 8'h0B;

  // Soft reset codes
  localparam logic [7:0] RST_CMD  = 8'h10;
  localparam logic [7:0] RST_IDLE = 8'h00;

  // Exposure period codes
  localparam logic [7:0] PERIOD_RST = 8'h02;
  localparam logic [7:0] PERIOD_MAX = 8'h07;

  // Interrupt pin codes
  localparam logic [7:0] IRQ_RISE = 8'h01;
  localparam logic [7:0] IRQ_FALL = 8'h02;
  localparam logic [7:0] IRQ_OFF  = 8'h03;
  localparam logic [7:0] IRQ_RST  = 8'h03;

  // Values after reset and fixed patterns
  localparam logic [7:0]  THR_LO_RST  = 8'h00;
  localparam logic [7:0]  THR_HI_RST  = 8'h08;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] TEST2_VALUE = 16'h5555;
  localparam logic [15:0] TEST3_VALUE = 16'hAAAA;
  // Arbitrary identifier value
  localparam logic [15:0] PART_CODE   = 16'h4C53;

  // Timing
  localparam int unsigned CLK_MHZ             = 100;
  localparam int unsigned SHORTEST_PERIOD_US  = 6250;
  localparam int unsigned SHORTEST_PERIOD_CYC = SHORTEST_PERIOD_US * CLK_MHZ;
  localparam int unsigned POWER_ON_WAIT_US    = 1500;
  localparam int unsigned POWER_ON_WAIT_CYC   = POWER_ON_WAIT_US * CLK_MHZ;
  localparam int unsigned SETTLE_PERIODS      = 3;
  localparam logic [3:0]  BITS_PER_BYTE       = 4'h8;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } lsrb_i2c_state_e;

  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } lsrb_wr_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } lsrb_bus_s;

endpackage

/* File: verilog/lsrb_sync.sv */
// Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes the inputs are slow compared with the clock.
`timescale 1ns/1ps
module lsrb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage1 <= {WIDTH{1'b1}};
      dout   <= {WIDTH{1'b1}};
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // lsrb_sync

/* File: verilog/lsrb_top.sv */
// Light sensor register bank with its two-wire bus slave and interrupt pin.
// Assumes SENSOR_COUNT comes from converter logic on SYS_CLK; SCL and SDA
// are open-drain pins outside the clock domain.
// Behaviour
// - Power code 0x00 stops and powers down; 0x08 runs normally, default.
// - Test codes 0x0A and 0x0B read counts 0x5555 and 0xAAAA; 0x09 reserved.
// - Illegal codes written to registers 0 to 3 store their default.
// - Defaults load only at reset; power commands keep register values.
// - Reset code 0x10 then STOP restarts measuring and clears the count.
// - Reset register clears itself to zero after the soft reset.
// - Period codes 0 to 7 give 800 down to 6.25 ms; default 200 ms.
// - When disabled the interrupt pin is released, never driven low.
// - Threshold low byte at 0x04, high byte 0x05, default 0x0800.
// - Count readable only, low at 0x06, high at 0x07, reset zero.
// - Fixed identifier read as low byte 0x08 and high byte 0x09.
// - Interrupt active while count exceeds threshold, inactive otherwise.
// - Powering down forces the interrupt output inactive.
// - Pointer advances after each data byte, for block writes and reads.
`timescale 1ns/1ps
module lsrb_top #(
  parameter int unsigned SHORTEST_CYC = lsrb_pkg::SHORTEST_PERIOD_CYC
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  output logic             INT_OUT,
  output logic             INT_OE_N,
  input  wire logic [15:0] SENSOR_COUNT
);

  lsrb_pkg::lsrb_bus_s       bus_raw;
  lsrb_pkg::lsrb_bus_s       bus_s;
  lsrb_pkg::lsrb_bus_s       bus_d;
  lsrb_pkg::lsrb_i2c_state_e state;
  lsrb_pkg::lsrb_wr_s        wr;

  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  ptr;
  logic        rw;
  logic        got_ack;
  logic        sda_low;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [7:0]  rd_byte;

  logic [7:0]  pwr_reg;
  logic [7:0]  rst_reg;
  logic [7:0]  period_reg;
  logic [7:0]  irq_sel;
  logic [7:0]  thr_lo;
  logic [7:0]  thr_hi;
  logic [15:0] light_count;
  logic        powered;
  logic        soft_reset_go;
  logic        power_on_cmd;
  logic        period_end;
  logic        irq_active;
  logic        pin_high;

  assign bus_raw = '{scl: SCL_IN, sda: SDA_IN};

  lsrb_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk  (SYS_CLK),
    .rstn (RSTN),
    .din  (bus_raw),
    .dout (bus_s)
  );

  // Edge and bus condition detection on synchronised lines
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      bus_d <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      bus_d <= bus_s;
    end
  end

  assign scl_rise = bus_s.scl & ~bus_d.scl;
  assign scl_fall = ~bus_s.scl & bus_d.scl;
  assign start_c  = bus_s.scl & bus_d.scl & bus_d.sda & ~bus_s.sda;
  assign stop_c   = bus_s.scl & bus_d.scl & ~bus_d.sda & bus_s.sda;

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (ptr)
      lsrb_pkg::REG_POWER:   rd_byte = pwr_reg;
      lsrb_pkg::REG_RESET:   rd_byte = rst_reg;
      lsrb_pkg::REG_PERIOD:  rd_byte = period_reg;
      lsrb_pkg::REG_IRQ_SEL: rd_byte = irq_sel;
      lsrb_pkg::REG_THR_LO:  rd_byte = thr_lo;
      lsrb_pkg::REG_THR_HI:  rd_byte = thr_hi;
      lsrb_pkg::REG_CNT_LO: begin
        if (pwr_reg == lsrb_pkg::PWR_TEST2) begin
          rd_byte = lsrb_pkg::TEST2_VALUE[7:0];
        end else if (pwr_reg == lsrb_pkg::PWR_TEST3) begin
          rd_byte = lsrb_pkg::TEST3_VALUE[7:0];
        end else begin
          rd_byte = light_count[7:0];
        end
      end
      lsrb_pkg::REG_CNT_HI: begin
        if (pwr_reg == lsrb_pkg::PWR_TEST2) begin
          rd_byte = lsrb_pkg::TEST2_VALUE[15:8];
        end else if (pwr_reg == lsrb_pkg::PWR_TEST3) begin
          rd_byte = lsrb_pkg::TEST3_VALUE[15:8];
        end else begin
          rd_byte = light_count[15:8];
        end
      end
      lsrb_pkg::REG_PART_LO: rd_byte = lsrb_pkg::PART_CODE[7:0];
      lsrb_pkg::REG_PART_HI: rd_byte = lsrb_pkg::PART_CODE[15:8];
      default:               rd_byte = 8'h00;
    endcase
  end

  // Bus slave: address, register pointer, write data and read data
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      state   <= lsrb_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      got_ack <= 1'b0;
      sda_low <= 1'b0;
      wr      <= '0;
    end else begin
      wr.stb <= 1'b0;
      if (start_c) begin
        state   <= lsrb_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        sda_low <= 1'b0;
      end else if (stop_c) begin
        state   <= lsrb_pkg::ST_IDLE;
        sda_low <= 1'b0;
      end else begin
        unique case (state)
          lsrb_pkg::ST_IDLE: begin
            sda_low <= 1'b0;
          end
          lsrb_pkg::ST_ADDR, lsrb_pkg::ST_REG, lsrb_pkg::ST_WDATA: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], bus_s.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == lsrb_pkg::BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              if (state == lsrb_pkg::ST_ADDR) begin
                if (shift[7:1] == lsrb_pkg::DEV_ADDR) begin
                  rw      <= shift[0];
                  sda_low <= 1'b1;
                  state   <= lsrb_pkg::ST_ADDR_ACK;
                end else begin
                  state <= lsrb_pkg::ST_IDLE;
                end
              end else if (state == lsrb_pkg::ST_REG) begin
                ptr     <= shift;
                sda_low <= 1'b1;
                state   <= lsrb_pkg::ST_REG_ACK;
              end else begin
                wr      <= '{stb: 1'b1, addr: ptr, data: shift};
                sda_low <= 1'b1;
                state   <= lsrb_pkg::ST_WDATA_ACK;
              end
            end
          end
          lsrb_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw) begin
                shift   <= rd_byte;
                sda_low <= ~rd_byte[7];
                ptr     <= ptr + 8'h01;
                state   <= lsrb_pkg::ST_RDATA;
              end else begin
                sda_low <= 1'b0;
                state   <= lsrb_pkg::ST_REG;
              end
            end
          end
          lsrb_pkg::ST_REG_ACK: begin
            if (scl_fall) begin
              sda_low <= 1'b0;
              state   <= lsrb_pkg::ST_WDATA;
            end
          end
          lsrb_pkg::ST_WDATA_ACK: begin
            if (scl_fall) begin
              sda_low <= 1'b0;
              ptr     <= ptr + 8'h01;
              state   <= lsrb_pkg::ST_WDATA;
            end
          end
          lsrb_pkg::ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == lsrb_pkg::BITS_PER_BYTE) begin
                bit_cnt <= 4'h0;
                sda_low <= 1'b0;
                state   <= lsrb_pkg::ST_RDATA_ACK;
              end else begin
                shift   <= {shift[6:0], 1'b0};
                sda_low <= ~shift[6];
              end
            end
          end
          lsrb_pkg::ST_RDATA_ACK: begin
            if (scl_rise) begin
              got_ack <= ~bus_s.sda;
            end else if (scl_fall) begin
              if (got_ack) begin
                shift   <= rd_byte;
                sda_low <= ~rd_byte[7];
                ptr     <= ptr + 8'h01;
                state   <= lsrb_pkg::ST_RDATA;
              end else begin
                state <= lsrb_pkg::ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Data pin drive: enable low while pulling the line low
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      SDA_OUT  <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else begin
      SDA_OUT  <= 1'b0;
      SDA_OE_N <= ~sda_low;
    end
  end

  assign soft_reset_go = stop_c && (rst_reg == lsrb_pkg::RST_CMD);
  assign power_on_cmd  = wr.stb && (wr.addr == lsrb_pkg::REG_POWER) &&
                         (pwr_reg == lsrb_pkg::PWR_OFF);
  assign powered       = (pwr_reg != lsrb_pkg::PWR_OFF);

  // Control registers; defaults only at reset, illegal codes take default
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      pwr_reg    <= lsrb_pkg::PWR_ON;
      period_reg <= lsrb_pkg::PERIOD_RST;
      irq_sel    <= lsrb_pkg::IRQ_RST;
      thr_lo     <= lsrb_pkg::THR_LO_RST;
      thr_hi     <= lsrb_pkg::THR_HI_RST;
    end else if (wr.stb) begin
      unique case (wr.addr)
        lsrb_pkg::REG_POWER: begin
          if (wr.data == lsrb_pkg::PWR_OFF || wr.data == lsrb_pkg::PWR_ON ||
              wr.data == lsrb_pkg::PWR_TEST1 ||
              wr.data == lsrb_pkg::PWR_TEST2 ||
              wr.data == lsrb_pkg::PWR_TEST3) begin
            pwr_reg <= wr.data;
          end else begin
            pwr_reg <= lsrb_pkg::PWR_ON;
          end
        end
        lsrb_pkg::REG_PERIOD: begin
          if (wr.data <= lsrb_pkg::PERIOD_MAX) begin
            period_reg <= wr.data;
          end else begin
            period_reg <= lsrb_pkg::PERIOD_RST;
          end
        end
        lsrb_pkg::REG_IRQ_SEL: begin
          if (wr.data >= lsrb_pkg::IRQ_RISE && wr.data <= lsrb_pkg::IRQ_OFF)
          begin
            irq_sel <= wr.data;
          end else begin
            irq_sel <= lsrb_pkg::IRQ_RST;
          end
        end
        lsrb_pkg::REG_THR_LO: thr_lo <= wr.data;
        lsrb_pkg::REG_THR_HI: thr_hi <= wr.data;
        default: begin
        end
      endcase
    end
  end

  // Soft reset register; clears itself when the reset is carried out
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rst_reg <= lsrb_pkg::RST_IDLE;
    end else if (wr.stb && wr.addr == lsrb_pkg::REG_RESET) begin
      if (wr.data == lsrb_pkg::RST_CMD) begin
        rst_reg <= lsrb_pkg::RST_CMD;
      end else begin
        rst_reg <= lsrb_pkg::RST_IDLE;
      end
    end else if (soft_reset_go) begin
      rst_reg <= lsrb_pkg::RST_IDLE;
    end
  end

  lsrb_period_timer #(
    .SHORTEST_CYC (SHORTEST_CYC)
  ) u_timer (
    .clk        (SYS_CLK),
    .rstn       (RSTN),
    .run        (powered),
    .restart    (soft_reset_go | power_on_cmd),
    .code       (period_reg[2:0]),
    .period_end (period_end)
  );

  // Light count: whole word at each period end, cleared by soft reset
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      light_count <= lsrb_pkg::CNT_RST;
    end else if (soft_reset_go) begin
      light_count <= lsrb_pkg::CNT_RST;
    end else if (period_end) begin
      light_count <= SENSOR_COUNT;
    end
  end

  // Threshold comparison, inactive while powered down
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      irq_active <= 1'b0;
    end else begin
      irq_active <= powered && (light_count > {thr_hi, thr_lo});
    end
  end

  always_comb begin
    pin_high = 1'b1;
    unique case (irq_sel)
      lsrb_pkg::IRQ_RISE: pin_high = irq_active;
      lsrb_pkg::IRQ_FALL: pin_high = ~irq_active;
      default:            pin_high = 1'b1;
    endcase
  end

  // Interrupt pin is open drain: enable low only while pulling low
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      INT_OUT  <= 1'b0;
      INT_OE_N <= 1'b1;
    end else begin
      INT_OUT  <= 1'b0;
      INT_OE_N <= pin_high;
    end
  end

endmodule // lsrb_top
